/* pma_lb_checker_asserts.sv */
module pma_lb_checker import pma_lb_pkg::*; #(
   parameter int LANES = LANES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [LANES*WORD_W-1:0] pcs_tx_data,
   input wire logic pcs_tx_valid,
   input wire logic pcs_tx_ready,
   input wire logic [LANES*WORD_W-1:0] pcs_rx_data,
   input wire logic pcs_rx_valid,
   input wire logic [LANES*WORD_W-1:0] serdes_tx_data,
   input wire logic serdes_tx_valid,
   input wire logic [LANES*WORD_W-1:0] serdes_rx_data,
   input wire logic serdes_rx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Shadow of the control word, snooped from finished writes
   logic [ADDR_W-1:0] addr_q;
   logic [8:0] data_q;
   logic [7:0] ctrl_q;
   logic [2:0] quiet_q;
   logic bdone, q, dir, rev, fec, take;
   assign bdone = s_axi_bvalid && s_axi_bready;
   always_ff @(posedge clk) begin
      if (s_axi_awvalid && s_axi_awready) begin
         addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         data_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
      end else if (bdone && addr_q == CTRL_OFS && data_q[8]) begin
         ctrl_q <= data_q[7:0];
      end
   end
   // Checks wait out a path switch and the gearbox flush behind it
   always_ff @(posedge clk) begin
      if (sys_rst || bdone || s_axi_awvalid || s_axi_wvalid) begin
         quiet_q <= 3'h0;
      end else if (quiet_q != 3'h7) begin
         quiet_q <= quiet_q + 3'h1;
      end
   end
   // Bypass slots thin the flow, so bypass modes are left out; the bench covers bypass normal and direct loopback only
   assign q = quiet_q == 3'h7 && !ctrl_q[2];
   assign fec = ctrl_q[3];
   assign dir = ctrl_q[0] && !ctrl_q[1] && fec;
   assign rev = ctrl_q[1] && !ctrl_q[0];
   assign take = pcs_tx_valid && pcs_tx_ready;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========
   // Path checks
   AST_DIR_ECHO: assert property (q && dir && take |=>
      pcs_rx_valid && pcs_rx_data == $past(pcs_tx_data))
      else $error("direct loopback word not returned to pcs rx");
   AST_DIR_TX: assert property (q && dir && take |-> ##1
      serdes_tx_valid && serdes_tx_data == $past(pcs_tx_data))
      else $error("direct loopback word not sent to serdes");
   AST_DIR_DROP: assert property (q && dir && !take |=> !pcs_rx_valid)
      else $error("serdes rx reached pcs in direct loopback");
   AST_REV_ECHO: assert property (q && rev && serdes_rx_valid |=>
      serdes_tx_valid && serdes_tx_data == $past(serdes_rx_data))
      else $error("reverse loopback word not resent");
   AST_REV_PASS: assert property (q && rev && fec && serdes_rx_valid |=>
      pcs_rx_valid && pcs_rx_data == $past(serdes_rx_data))
      else $error("reverse loopback rx word not passed to pcs");
   AST_REV_DROP: assert property (q && rev && !serdes_rx_valid |->
      pcs_tx_ready ##1 !serdes_tx_valid)
      else $error("pcs tx word reached serdes in reverse loopback");
   AST_NOFEC_RX: assert property (q && !fec && serdes_rx_valid |=>
      pcs_rx_valid && pcs_rx_data[NFEC_W-1:0] == $past(serdes_rx_data[NFEC_W-1:0]))
      else $error("no-fec rx word not passed in 40-bit form");
   AST_NORMAL_TX: assert property (q && fec && !dir && !rev && take |=>
      serdes_tx_valid && serdes_tx_data == $past(pcs_tx_data))
      else $error("normal tx path not kept");
endmodule : pma_lb_checker
bind pma_loopback_path pma_lb_checker #(.LANES(LANES)) u_pma_lb_checker (
   .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .pcs_tx_data, .pcs_tx_valid, .pcs_tx_ready, .pcs_rx_data, .pcs_rx_valid,
   .serdes_tx_data, .serdes_tx_valid, .serdes_rx_data, .serdes_rx_valid);

/* pma_lb_pkg.sv */
// Overview of operation
// R1: Single-lane bypass at 10G/25G without FEC skips every gearbox.
// R2: Single-lane bypass is only allowed with a 32-bit serializer width.
// R3: Direct loopback returns every PCS transmit word to PCS receive.
// R4: Direct loopback still sends PCS transmit data to the serializer.
// R5: Direct loopback discards serializer receive data.
// R6: Reverse loopback resends every serializer receive word on serializer transmit. In bypass the code resends only words in four of every five slots.
// R7: Reverse loopback still delivers serializer receive data to PCS unchanged.
// R8: Reverse loopback drops all PCS transmit data.
// R9: Both loopbacks run on the one system reference clock, no rate buffer.
// R10: Loopback selection applies to all lanes together, never a mix.
// R11: Clock source keeps transmit serializer clock at mode rate in direct loopback.
// R12: Clock source runs both serializer clocks at mode rate, equal widths.
// R13: Direct loopback only with RS-FEC, not plain 64b/66b at 10G/25G. The code also allows it in single-lane bypass without RS-FEC.
// R14: Without RS-FEC, 66-bit blocks are geared to 40 or 80-bit words.
// R15: Without RS-FEC, PCS receive always takes 40-bit words. In bypass the code passes only lane 0's low 32 bits.
// R16: Loopback in single-lane bypass runs at 32/40 of line rate.
// R17: Each loopback mode has its own configuration register bit.
// R18: Both loopbacks enabled together is rejected; normal path is kept.
package pma_lb_pkg;

   // ======================================================
   // Widths and counts
   localparam int LANES_DEF = 4;
   localparam int LANES_MAX = 8;
   localparam int WORD_W = 80;
   localparam int BLK_W = 66;
   localparam int NFEC_W = 40;
   localparam int BYP_W = 32;
   localparam int ACC_W = BLK_W + WORD_W;
   localparam int ADDR_W = 8;
   // Four of every five slots carry data in bypass loopback
   localparam logic [2:0] THR_LAST = 3'h4;

   // ======================================================
   // Register map
   localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] INFO_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] LOOP_CNT_OFS = 8'h0C;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int CTRL_W = 8;
   localparam int STATUS_W = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================
   // Field encodings
   localparam logic [1:0] WID_32 = 2'h0;
   localparam logic [1:0] WID_40 = 2'h1;
   localparam logic [1:0] WID_80 = 2'h2;
   localparam logic [1:0] RATE_10G = 2'h0;
   localparam logic [1:0] RATE_25G = 2'h1;

   typedef enum {PATH_NORMAL, PATH_DIRECT, PATH_REVERSE} path_e;

   // Bit 0 is direct loopback, bit 1 reverse loopback
   typedef struct packed {
      logic [1:0] width;
      logic [1:0] rate;
      logic rsfec;
      logic bypass_sel;
      logic rev_lb;
      logic dir_lb;
   } ctrl_s;

   typedef struct packed {
      logic both_rejected;
      logic dir_rejected;
      logic byp_rejected;
      logic reverse_on;
      logic direct_on;
      logic bypass_on;
      logic gearbox_on;
   } status_s;

endpackage : pma_lb_pkg

/* pma_loopback_path.sv */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
module pma_loopback_path import pma_lb_pkg::*; #(
   parameter int LANES = LANES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [LANES*WORD_W-1:0] pcs_tx_data,
   input wire logic pcs_tx_valid,
   output logic pcs_tx_ready,
   output logic [LANES*WORD_W-1:0] pcs_rx_data,
   output logic pcs_rx_valid,
   output logic [LANES*WORD_W-1:0] serdes_tx_data,
   output logic serdes_tx_valid,
   input wire logic [LANES*WORD_W-1:0] serdes_rx_data,
   input wire logic serdes_rx_valid
);

   localparam int BUS_W = LANES * WORD_W;
   if (LANES < 1 || LANES > LANES_MAX) begin : g_chk
      $error("LANES must lie between 1 and LANES_MAX");
   end

   // ======================================================
   // Register bus state
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_have_q, w_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   ctrl_s ctrl_q;
   status_s status_q;
   logic [15:0] loop_cnt_q;
   logic aw_take, w_take, wr_fire, ar_take;
   assign aw_take = s_axi_awvalid & awready_q;
   assign w_take = s_axi_wvalid & wready_q;
   assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
   assign ar_take = s_axi_arvalid & arready_q;

   // ======================================================
   // Mode decode
   logic bypass_ok, dir_req, rev_req, both_req;
   path_e path_d, path_q;
   logic bypass_d, bypass_q, gear_d, gear_q;
   logic cfg_chg_q;
   always_comb begin
      bypass_ok = ctrl_q.bypass_sel & ~ctrl_q.rsfec & (ctrl_q.width == WID_32)
         & (ctrl_q.rate == RATE_10G || ctrl_q.rate == RATE_25G); // [R1] [R2]
      both_req = ctrl_q.dir_lb & ctrl_q.rev_lb; // [R18]
      dir_req = ctrl_q.dir_lb & ~both_req
         & (ctrl_q.rsfec | bypass_ok); // [R13] [R16] [R17]
      rev_req = ctrl_q.rev_lb & ~both_req; // [R17]
      if (dir_req) begin
         path_d = PATH_DIRECT;
      end else if (rev_req) begin
         path_d = PATH_REVERSE;
      end else begin
         path_d = PATH_NORMAL; // [R18]
      end
      bypass_d = bypass_ok;
      gear_d = ~ctrl_q.rsfec & ~bypass_ok; // [R14]
   end

   // One mode register drives every lane, so lanes never differ
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         path_q <= PATH_NORMAL;
         bypass_q <= 1'b0;
         gear_q <= 1'b0;
      end else begin
         path_q <= path_d; // [R10]
         bypass_q <= bypass_d;
         gear_q <= gear_d;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_q <= '0;
      end else begin
         status_q.both_rejected <= both_req;
         status_q.dir_rejected <= ctrl_q.dir_lb & ~both_req & ~dir_req;
         status_q.byp_rejected <= ctrl_q.bypass_sel & ~bypass_ok;
         status_q.reverse_on <= (path_d == PATH_REVERSE);
         status_q.direct_on <= (path_d == PATH_DIRECT);
         status_q.bypass_on <= bypass_d;
         status_q.gearbox_on <= gear_d;
      end
   end

   // ======================================================
   // Bypass loopback throttle
   logic [2:0] thr_q, thr_d;
   logic slot_ok, slot_ok_d;
   logic thr_run;
   assign thr_run = bypass_q & (path_q != PATH_NORMAL);
   assign slot_ok = ~thr_run | (thr_q != THR_LAST); // [R16]
   always_comb begin
      if (~thr_run || thr_q == THR_LAST) begin
         thr_d = 3'h0;
      end else begin
         thr_d = thr_q + 3'h1;
      end
      slot_ok_d = ~(bypass_d & (path_d != PATH_NORMAL))
         | (thr_d != THR_LAST);
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thr_q <= 3'h0;
      end else begin
         thr_q <= thr_d;
      end
   end

   // ======================================================
   // Transmit gearbox, 66-bit blocks to 40 or 80-bit words
   logic [7:0] cnt_q, cnt_d, obits;
   logic ready_q, ready_d;
   logic take, gb_load, gb_emit;
   logic [BUS_W-1:0] gb_word;
   assign take = pcs_tx_valid & ready_q;
   assign obits = (ctrl_q.width == WID_80) ? 8'(WORD_W) : 8'(NFEC_W);
   assign gb_emit = gear_q & (cnt_q >= obits); // [R14]
   assign gb_load = gear_q & take & ~gb_emit;
   always_comb begin
      if (cfg_chg_q || ~gear_q) begin
         cnt_d = 8'h00;
      end else if (gb_emit) begin
         cnt_d = cnt_q - obits;
      end else if (gb_load) begin
         cnt_d = cnt_q + 8'(BLK_W);
      end else begin
         cnt_d = cnt_q;
      end
   end
   // Ready is registered from next state so the PCS sees a flop
   always_comb begin
      if (path_d == PATH_REVERSE) begin
         ready_d = 1'b1; // [R8]
      end else if (gear_d) begin
         ready_d = (cnt_d < obits) & ~gb_emit;
      end else if (bypass_d && path_d == PATH_DIRECT) begin
         ready_d = slot_ok_d; // [R16]
      end else begin
         ready_d = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 8'h00;
         ready_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ready_q <= ready_d;
      end
   end

   for (genvar i = 0; i < LANES; i++) begin : g_gear
      logic [BLK_W-1:0] blk;
      logic [ACC_W-1:0] acc_q;
      assign blk = pcs_tx_data[i*WORD_W +: BLK_W];
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            acc_q <= '0;
         end else if (cfg_chg_q || ~gear_q) begin
            acc_q <= '0;
         end else if (gb_emit) begin
            acc_q <= acc_q >> obits;
         end else if (gb_load) begin
            acc_q <= acc_q | ({{(ACC_W-BLK_W){1'b0}}, blk} << cnt_q);
         end
      end
      assign gb_word[i*WORD_W +: WORD_W] = (obits == 8'(NFEC_W))
         ? {{(WORD_W-NFEC_W){1'b0}}, acc_q[NFEC_W-1:0]} : acc_q[WORD_W-1:0];
   end

   // ======================================================
   // Word shaping per mode
   function automatic logic [BUS_W-1:0] shape(
      input logic [BUS_W-1:0] d,
      input logic byp,
      input logic nfec
   );
      logic [BUS_W-1:0] r;
      r = '0;
      if (byp) begin
         r[BYP_W-1:0] = d[BYP_W-1:0];
      end else if (nfec) begin
         for (int l = 0; l < LANES; l++) begin
            r[l*WORD_W +: NFEC_W] = d[l*WORD_W +: NFEC_W];
         end
      end else begin
         r = d;
      end
      return r;
   endfunction : shape

   logic [BUS_W-1:0] tx_word;
   logic tx_vld;
   assign tx_word = gear_q ? gb_word
      : shape(pcs_tx_data, bypass_q, 1'b0); // [R1]
   assign tx_vld = gear_q ? gb_emit : take;

   // ======================================================
   // Path selection, all on clk
   logic [BUS_W-1:0] stx_q, prx_q;
   logic stx_vld_q, prx_vld_q;
   always_ff @(posedge clk) begin // [R9]
      if (sys_rst) begin
         stx_q <= '0;
         stx_vld_q <= 1'b0;
      end else if (path_q == PATH_REVERSE) begin
         stx_q <= shape(serdes_rx_data, bypass_q, 1'b0); // [R6] [R8]
         stx_vld_q <= serdes_rx_valid & slot_ok; // [R16]
      end else begin
         stx_q <= tx_word; // [R4]
         stx_vld_q <= tx_vld;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prx_q <= '0;
         prx_vld_q <= 1'b0;
      end else if (path_q == PATH_DIRECT) begin
         prx_q <= shape(pcs_tx_data, bypass_q, 1'b0); // [R3] [R5]
         prx_vld_q <= take;
      end else begin
         prx_q <= shape(serdes_rx_data, bypass_q, gear_q); // [R7] [R15]
         prx_vld_q <= serdes_rx_valid;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         loop_cnt_q <= 16'h0000;
      end else if (wr_fire && aw_addr_q == LOOP_CNT_OFS) begin
         loop_cnt_q <= 16'h0000;
      end else if ((path_q == PATH_DIRECT && take)
         || (path_q == PATH_REVERSE && serdes_rx_valid && slot_ok)) begin
         loop_cnt_q <= loop_cnt_q + 16'h0001;
      end
   end

   // ======================================================
   // AXI4-Lite write channel
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awready_q <= 1'b1;
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (aw_take) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
         awready_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wready_q <= 1'b1;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (w_take) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
         wready_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         unique case (aw_addr_q)
            CTRL_OFS, STATUS_OFS, INFO_OFS, LOOP_CNT_OFS: bresp_q <= RESP_OKAY;
            default: bresp_q <= RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Config changes flush the gearbox so no stale bits leak
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
         cfg_chg_q <= 1'b0;
      end else begin
         cfg_chg_q <= 1'b0;
         if (wr_fire && aw_addr_q == CTRL_OFS && w_strb_q[0]) begin
            ctrl_q <= w_data_q[CTRL_W-1:0]; // [R17]
            cfg_chg_q <= 1'b1;
         end
      end
   end

   // ======================================================
   // AXI4-Lite read channel
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         unique case (s_axi_araddr)
            CTRL_OFS: rdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
            STATUS_OFS: rdata_q <= {{(32-STATUS_W){1'b0}}, status_q};
            INFO_OFS: rdata_q <= 32'(LANES);
            LOOP_CNT_OFS: rdata_q <= {16'h0000, loop_cnt_q};
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ======================================================
   // Outputs
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign pcs_tx_ready = ready_q;
   assign pcs_rx_data = prx_q;
   assign pcs_rx_valid = prx_vld_q;
   assign serdes_tx_data = stx_q;
   assign serdes_tx_valid = stx_vld_q;

endmodule : pma_loopback_path

/* serdes_far_model.sv */
module serdes_far_model #(
   parameter int DW = 320
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [DW-1:0] word,
   output logic [DW-1:0] serdes_rx_data,
   output logic serdes_rx_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Receive lanes on the block's own clock, same width both ways
   // Idle lanes toggle so a stale word never passes for a fresh one
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         serdes_rx_valid <= 1'b0;
         serdes_rx_data <= '0;
      end else begin
         serdes_rx_valid <= go;
         serdes_rx_data <= go ? word : ~serdes_rx_data;
      end
   end
endmodule : serdes_far_model

/* tb_pma_loopback_path.sv */
module tb_pma_loopback_path import pma_lb_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LANES = 2;
   localparam int DW = LANES * WORD_W;
   logic clk = 1'b0, sys_rst = 1'b1, ser_go = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, pcs_tx_valid = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, pcs_tx_ready, pcs_rx_valid, serdes_tx_valid;
   logic serdes_rx_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [DW-1:0] pcs_tx_data = '0, ser_word = '0, rx_got, tx_got;
   logic [DW-1:0] pcs_rx_data, serdes_tx_data, serdes_rx_data;
   logic [7:0] tbl [9] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h01, 8'h11, 8'h04,
                          8'h44, 8'h05};
   int err_count = 0, n_checks = 0, rx_n = 0, tx_n = 0, cyc = 0, lp = 0;
   pma_loopback_path #(.LANES(LANES)) u_pma_loopback_path (
      .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pcs_tx_data, .pcs_tx_valid, .pcs_tx_ready, .pcs_rx_data, .pcs_rx_valid,
      .serdes_tx_data, .serdes_tx_valid, .serdes_rx_data, .serdes_rx_valid);
   serdes_far_model #(.DW(DW)) u_serdes_far_model (.clk, .sys_rst, .go(ser_go),
      .word(ser_word), .serdes_rx_data, .serdes_rx_valid);
   initial begin
      forever #5 clk = ~clk;
   end
   // ==========
   // Expectations
   function automatic logic [DW-1:0] rnd();
      logic [DW-1:0] v;
      for (int i = 0; i < DW / 32; i++) begin
         v[i*32 +: 32] = $urandom;
      end
      return v;
   endfunction : rnd
   function automatic logic [DW-1:0] lo(input logic [DW-1:0] v, input int n);
      logic [DW-1:0] m;
      m = '0;
      for (int i = 0; i < LANES * WORD_W; i++) begin
         m[i] = (i % WORD_W < n) ? v[i] : 1'b0;
      end
      return m;
   endfunction : lo
   function automatic status_s exp_st(input ctrl_s c);
      status_s s;
      s.bypass_on = c.bypass_sel && c.width == WID_32 && !c.rsfec &&
         (c.rate == RATE_10G || c.rate == RATE_25G);
      s.byp_rejected = c.bypass_sel && !s.bypass_on;
      s.gearbox_on = !c.rsfec && !s.bypass_on;
      s.direct_on = c.dir_lb && !c.rev_lb && (c.rsfec || s.bypass_on);
      s.reverse_on = c.rev_lb && !c.dir_lb;
      s.dir_rejected = c.dir_lb && !c.rev_lb && !s.direct_on;
      s.both_rejected = c.dir_lb && c.rev_lb;
      return s;
   endfunction : exp_st
   // ==========
   // Drivers and checks
   task automatic chk(input string n, input logic [DW-1:0] e, g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // Leading edge keeps a ready from being lowered and raised in one step
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic pcs_send(input logic [DW-1:0] w);
      pcs_tx_data <= w;
      pcs_tx_valid <= 1'b1;
      do @(posedge clk); while (pcs_tx_ready !== 1'b1);
      pcs_tx_valid <= 1'b0;
      pcs_tx_data <= ~w;
   endtask : pcs_send
   always @(posedge clk) begin
      cyc++;
      if (pcs_rx_valid === 1'b1) begin
         rx_n++;
         rx_got = pcs_rx_data;
      end
      if (serdes_tx_valid === 1'b1) begin
         tx_n++;
         tx_got = serdes_tx_data;
      end
      if (cyc == 6000) begin
         err_count++;
         give_verdict();
      end
   end
   // ==========
   // Main sequence
   initial begin
      ctrl_s c;
      status_s s;
      logic [31:0] d;
      logic [1:0] r;
      logic [DW-1:0] a, b;
      int n0, t0, wd;
      void'($urandom(32'hFB86A385));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      axi_rd(CTRL_OFS, d, r);
      chk("ctrl reset", DW'(CTRL_RST), DW'(d));
      axi_rd(INFO_OFS, d, r);
      chk("info", DW'(LANES), DW'(d));
      axi_rd(8'h10, d, r);
      chk("rd unmapped", DW'(RESP_SLVERR), DW'(r));
      axi_wr(8'h10, 32'h000000FF, r);
      chk("wr unmapped", DW'(RESP_SLVERR), DW'(r));
      $display("test reset done");
      repeat (2) begin
         foreach (tbl[i]) begin
            c = ctrl_s'(tbl[i]);
            s = exp_st(c);
            axi_wr(CTRL_OFS, {24'h000000, c}, r);
            repeat (8) @(posedge clk);
            axi_rd(CTRL_OFS, d, r);
            chk("ctrl", DW'(c), DW'(d));
            axi_rd(STATUS_OFS, d, r);
            chk("status", DW'(s), DW'(d[STATUS_W-1:0]));
            // Bypass words use lane 0's low 32 bits only
            a = s.bypass_on ? DW'($urandom)
               : lo(rnd(), c.rsfec ? WORD_W : BLK_W);
            b = s.bypass_on ? DW'($urandom) : rnd();
            wd = (c.rsfec || s.bypass_on) ? WORD_W : NFEC_W;
            if (s.direct_on || s.reverse_on) lp++;
            n0 = rx_n;
            t0 = tx_n;
            pcs_send(a);
            repeat (4) @(posedge clk);
            chk("rx n a", DW'(s.direct_on), DW'(rx_n - n0));
            if (s.direct_on) chk("rx a", a, rx_got);
            chk("tx n a", DW'(!s.reverse_on), DW'(tx_n - t0));
            if (!s.reverse_on) chk("tx a", lo(a, wd), tx_got);
            n0 = rx_n;
            t0 = tx_n;
            ser_go <= 1'b1;
            ser_word <= b;
            @(posedge clk);
            ser_go <= 1'b0;
            repeat (4) @(posedge clk);
            chk("rx n b", DW'(!s.direct_on), DW'(rx_n - n0));
            if (!s.direct_on) chk("rx b", lo(b, wd), rx_got);
            chk("tx n b", DW'(s.reverse_on), DW'(tx_n - t0));
            if (s.reverse_on) chk("tx b", b, tx_got);
            $display("test ctrl %h done", c);
         end
      end
      axi_rd(LOOP_CNT_OFS, d, r);
      chk("loop count", DW'(lp), DW'(d));
      axi_wr(LOOP_CNT_OFS, 32'h00000000, r);
      axi_rd(LOOP_CNT_OFS, d, r);
      chk("loop clear", DW'(0), DW'(d));
      $display("test loop count done");
      give_verdict();
   end
endmodule : tb_pma_loopback_path
